// file: hdl/dpm_top.sv
// Purpose: Data-path front end: bus latch, operand, address and
//          constant multiplexers with byte sign extension.
// Assumes: Control fields and pulses are synchronous to clk_i.
// Notes: Every output is registered; latch outputs and table trap vectors arrive two cycles after their inputs.
// Behaviour
// RULE1: Latch 16 bits plus inverted bit 14.
// RULE2: Export latch bits 3 to 0.
// RULE3: Latch loads on enabled pulse or strobe.
// RULE4: Each mux picks one of four inputs.
// RULE5: A mux feeds ALU from operand registers.
// RULE6: Small constants only four bits, up to 10.
// RULE7: Vector mux output bit 0 always zero.
// RULE8: Address mux gives 16-bit virtual address.
// RULE9: Sign extension blocks high-byte B select.
// RULE10: Start vector blocks B bits 11, 08.
// RULE11: Constant two suppressed without float step.
// RULE12: Small constant output exported for status.
// RULE13: Extend sign of latch or source byte.
// RULE14: Physical bits 17:16 set when 15:13 ones.
// RULE15: Vector mux picks start, trap, loop, branch.
// RULE16: Fitted jumper gives one per bit.
// RULE17: Vectors even-word; bit 7 picks range.
// RULE18: Unlisted trap condition gives vector 4.
// RULE19: Software loads halved emulator trap vectors; the table byte is used as the vector without doubling.
// RULE20: Loop offset is 6 bits shifted left.
// RULE21: Branch offset shifted, sign-extended to 16.
// RULE22: Select codes use a fixed mapping.
// RULE23: Trap vectors come from a writable table.
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
module dpm_top
    import dpm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] bus_latch_input_mux_i,
    input wire logic latch_load_enable_i,
    input wire logic phase_one_pulse_i,
    input wire logic long_pause_load_strobe_i,
    input wire logic [15:0] source_operand_reg_i,
    input wire logic [15:0] dest_operand_reg_i,
    input wire logic [15:0] pcb_i,
    input wire logic [15:0] shifter_i,
    input wire logic [1:0] a_sel_i,
    input wire logic [1:0] b_sel_i,
    input wire logic [1:0] addr_sel_i,
    input wire logic [1:0] small_sel_i,
    input wire logic [1:0] const_select_bits_i,
    input wire logic vec_enable_i,
    input wire logic byte_move_sign_extend_i,
    input wire logic float_bus_op_i,
    input wire logic float_address_step_i,
    input wire logic [3:0] src_const_i,
    input wire logic [3:0] dst_const_i,
    input wire logic [7:2] start_vector_i,
    input wire logic trap_active_i,
    input wire logic [3:0] trap_cond_i,
    input wire logic mmu_enable_i,
    output logic [15:0] bus_latch_o,
    output logic bus_latch_b14_n_o,
    output logic [3:0] bus_latch_cc_o,
    output logic [15:0] a_operand_mux_o,
    output logic [15:0] b_operand_mux_o,
    output logic [15:0] address_out_mux_o,
    output logic [1:0] phys_addr_top_bits_o,
    output logic [3:0] small_const_mux_o,
    output logic [15:0] vector_offset_mux_o
);
    dpm_tbl_if tbl ();

    logic [31:0] ctrl_reg;
    logic [15:0] bus_latch_reg;
    logic bus_latch_b14_n_reg;
    logic [3:0] small_const_mux;
    logic [15:0] vector_offset_mux;
    logic [15:0] start_vector;
    logic [15:0] trap_vector;
    logic [15:0] a_mux;
    logic [15:0] const_word;
    logic [15:0] b_low_src;
    logic [15:0] b_high_src;
    logic [15:0] b_mux;
    logic [15:0] addr_mux;
    logic [1:0] phys_top;
    logic [1:0] b_high_sel;
    logic const_sign_extend;
    logic sign_bit;
    logic start_sel;
    logic latch_load;
    logic wb_req;
    logic [31:0] rd_data;
    logic tbl_hit;
    logic phys_extend_flag;
    logic wb_wr;

    dpm_trap_table u_table (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tbl(tbl.owner)
    );

    // The latch loads from the timing pulse or the long-pause strobe.
    assign latch_load = latch_load_enable_i &&
        (phase_one_pulse_i || long_pause_load_strobe_i); // RULE3

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_latch_reg <= 16'h0000;
            bus_latch_b14_n_reg <= 1'b1;
        end else if (latch_load) begin // RULE3
            bus_latch_reg <= bus_latch_input_mux_i; // RULE1
            bus_latch_b14_n_reg <= ~bus_latch_input_mux_i[14]; // RULE1
        end
    end

    // Small constant mux; negative values come from ALU subtraction.
    always_comb begin
        case (small_sel_i) // RULE22
            K0_SRC: small_const_mux = src_const_i;
            K0_DST: small_const_mux = dst_const_i;
            K0_ONE: small_const_mux = K0_VAL_ONE; // RULE11
            default: begin
                // Float steps lacking the increment signal get zero.
                if (float_bus_op_i && !float_address_step_i) begin
                    small_const_mux = 4'h0; // RULE11
                end else begin
                    small_const_mux = K0_VAL_TWO; // RULE11
                end
            end
        endcase
    end

    // Start vector: jumpers set bits, range bit fills the top.
    // Bits 11 and 08 stay clear, so the high range sits at 173200 octal.
    always_comb begin
        start_vector = {{4{start_vector_i[START_RANGE_BIT]}}, 1'b0,
            {2{start_vector_i[START_RANGE_BIT]}}, 1'b0,
            start_vector_i, 2'b00}; // RULE16 RULE17 RULE10
    end

    // Trap vector from the table, or 4 when no trap is active or no condition is coded.
    // The table read is registered, so a new condition shows a cycle late.
    assign tbl.rd_addr = trap_cond_i; // RULE23
    always_comb begin
        if (trap_active_i && trap_cond_i != 4'h0) begin
            trap_vector = {8'h00, tbl.rd_data}; // RULE23 RULE19
        end else begin
            trap_vector = {8'h00, TRAP_DEFAULT}; // RULE18
        end
    end

    // Vector and offset mux; bit 0 is cleared after the case.
    always_comb begin
        case (const_select_bits_i) // RULE15
            K1_START: vector_offset_mux = start_vector;
            K1_TRAP: vector_offset_mux = {trap_vector[15:2], 2'b00};
            K1_LOOP: vector_offset_mux =
                {9'h000, bus_latch_reg[5:0], 1'b0}; // RULE20
            default: vector_offset_mux = {{7{bus_latch_reg[7]}},
                bus_latch_reg[7:0], 1'b0}; // RULE21
        endcase
        vector_offset_mux[0] = 1'b0; // RULE7
    end

    // Constant input to the B mux, bits 11 and 08 blocked for start.
    assign start_sel = vec_enable_i && (const_select_bits_i == K1_START);
    always_comb begin
        if (vec_enable_i) begin
            const_word = vector_offset_mux;
        end else begin
            const_word = {12'h000, small_const_mux}; // RULE6
        end
        if (start_sel) begin
            const_word[START_BLOCK_HI] = 1'b0; // RULE10
            const_word[START_BLOCK_LO] = 1'b0; // RULE10
        end
    end

    // A operand mux.
    always_comb begin
        case (a_sel_i) // RULE4 RULE22
            ASEL_SRC: a_mux = source_operand_reg_i; // RULE5
            ASEL_DST: a_mux = dest_operand_reg_i; // RULE5
            ASEL_PCB: a_mux = pcb_i;
            default: a_mux = bus_latch_reg;
        endcase
    end

    // Sign of the byte being moved, from latch or source register.
    assign const_sign_extend = byte_move_sign_extend_i;
    assign sign_bit = (b_sel_i == BSEL_SRC) ?
        source_operand_reg_i[7] : bus_latch_reg[7]; // RULE13

    // High-byte select is blocked during byte sign extension.
    assign b_high_sel = byte_move_sign_extend_i ?
        BSEL_CONST : b_sel_i; // RULE9

    // Low byte follows its select; the high byte may be overridden.
    always_comb begin
        case (b_sel_i) // RULE4 RULE22
            BSEL_CONST: b_low_src = const_word;
            BSEL_LATCH: b_low_src = bus_latch_reg;
            BSEL_SRC: b_low_src = source_operand_reg_i;
            default: b_low_src = dest_operand_reg_i;
        endcase
        case (b_high_sel) // RULE9
            BSEL_CONST: begin
                if (const_sign_extend) begin
                    b_high_src = {{8{sign_bit}}, 8'h00}; // RULE13 RULE6
                end else begin
                    b_high_src = const_word;
                end
            end
            BSEL_LATCH: b_high_src = bus_latch_reg;
            BSEL_SRC: b_high_src = source_operand_reg_i;
            default: b_high_src = dest_operand_reg_i;
        endcase
        b_mux = {b_high_src[15:8], b_low_src[7:0]};
    end

    // Bus address mux and physical extension.
    always_comb begin
        case (addr_sel_i) // RULE4 RULE8 RULE22
            ADSEL_PCB: addr_mux = pcb_i;
            ADSEL_SRC: addr_mux = source_operand_reg_i;
            ADSEL_DST: addr_mux = dest_operand_reg_i;
            default: addr_mux = shifter_i;
        endcase
    end

    // The top physical bits only matter while translation is off.
    assign phys_extend_flag = ctrl_reg[CTRL_EXT_BIT] && !mmu_enable_i;
    assign phys_top = (phys_extend_flag && (&addr_mux[15:13])) ?
        2'b11 : 2'b00; // RULE14

    // Latch outputs trail the latch itself by one cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_latch_o <= 16'h0000;
            bus_latch_b14_n_o <= 1'b1;
            bus_latch_cc_o <= 4'h0;
        end else begin
            bus_latch_o <= bus_latch_reg; // RULE1
            bus_latch_b14_n_o <= bus_latch_b14_n_reg; // RULE1
            bus_latch_cc_o <= bus_latch_reg[3:0]; // RULE2
        end
    end

    // Operand outputs toward the ALU.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_operand_mux_o <= 16'h0000;
            b_operand_mux_o <= 16'h0000;
        end else begin
            a_operand_mux_o <= a_mux; // RULE5
            b_operand_mux_o <= b_mux; // RULE4
        end
    end

    // Constant outputs, also exported for the status recorder.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            small_const_mux_o <= 4'h0;
            vector_offset_mux_o <= 16'h0000;
        end else begin
            small_const_mux_o <= small_const_mux; // RULE12
            vector_offset_mux_o <= vector_offset_mux; // RULE7
        end
    end

    // Address outputs toward the bus drivers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            address_out_mux_o <= 16'h0000;
            phys_addr_top_bits_o <= 2'b00;
        end else begin
            address_out_mux_o <= addr_mux; // RULE8
            phys_addr_top_bits_o <= phys_top; // RULE14
        end
    end

    // Wishbone slave: one wait state, ack for one cycle.
    // A standing ack masks the request, so one cycle gives one answer.
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Writes land at the edge where the master sees ack high.
    assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
        wb_ack_o;
    assign tbl_hit = (wb_adr_i[7:0] >= REG_TBL_BASE) &&
        (wb_adr_i[7:0] <= REG_TBL_END) && (wb_adr_i[31:8] == 24'h000000);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Control holds the physical extension enable, set by reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wb_wr && wb_adr_i == {24'h000000, REG_CTRL}) begin
            ctrl_reg <= {31'h0000_0000, wb_dat_i[CTRL_EXT_BIT]};
        end
    end

    // Table writes take the low byte; the table clears bit 0 itself.
    assign tbl.wr_en = wb_wr && tbl_hit;
    assign tbl.wr_addr = wb_adr_i[TBL_AW+1:2];
    assign tbl.wr_data = wb_dat_i[VEC_W-1:0];

    // Read decode; table entries and unmapped offsets read as zero.
    always_comb begin
        if (wb_adr_i == {24'h000000, REG_CTRL}) begin
            rd_data = ctrl_reg;
        end else if (wb_adr_i == {24'h000000, REG_STATUS}) begin
            rd_data = {13'h0000, phys_addr_top_bits_o,
                bus_latch_b14_n_reg, bus_latch_reg};
        end else if (wb_adr_i == {24'h000000, REG_CONST}) begin
            rd_data = {12'h000, small_const_mux_o,
                vector_offset_mux_o};
        end else begin
            rd_data = 32'h0000_0000;
        end
    end

    // Read data holds until the next read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_data;
        end
    end
endmodule

// file: hdl/dpm_pkg.sv
// Purpose: Shared constants for the data-path multiplexer block.
// Assumes: One 125 MHz clock, synchronous active-high reset.
// Notes: Select codes and register offsets are fixed here.
package dpm_pkg;
    localparam int DATA_W = 16;
    localparam int TBL_AW = 4;
    localparam int TBL_DEPTH = 16;
    localparam int VEC_W = 8;

    // A operand select codes.
    localparam logic [1:0] ASEL_SRC = 2'h0;
    localparam logic [1:0] ASEL_DST = 2'h1;
    localparam logic [1:0] ASEL_PCB = 2'h2;
    localparam logic [1:0] ASEL_LATCH = 2'h3;

    // B operand select codes; code 0 is the constant input.
    localparam logic [1:0] BSEL_CONST = 2'h0;
    localparam logic [1:0] BSEL_LATCH = 2'h1;
    localparam logic [1:0] BSEL_SRC = 2'h2;
    localparam logic [1:0] BSEL_DST = 2'h3;

    // Bus address select codes.
    localparam logic [1:0] ADSEL_PCB = 2'h0;
    localparam logic [1:0] ADSEL_SRC = 2'h1;
    localparam logic [1:0] ADSEL_DST = 2'h2;
    localparam logic [1:0] ADSEL_SHIFT = 2'h3;

    // Small constant select codes.
    localparam logic [1:0] K0_SRC = 2'h0;
    localparam logic [1:0] K0_DST = 2'h1;
    localparam logic [1:0] K0_ONE = 2'h2;
    localparam logic [1:0] K0_TWO = 2'h3;

    // Vector and offset select codes.
    localparam logic [1:0] K1_START = 2'h0;
    localparam logic [1:0] K1_TRAP = 2'h1;
    localparam logic [1:0] K1_LOOP = 2'h2;
    localparam logic [1:0] K1_BRANCH = 2'h3;

    localparam logic [3:0] K0_VAL_ONE = 4'h1;
    localparam logic [3:0] K0_VAL_TWO = 4'h2;
    localparam logic [VEC_W-1:0] TRAP_DEFAULT = 8'h04;
    localparam logic [VEC_W-1:0] TBL_RESET = 8'h00;
    localparam int START_RANGE_BIT = 7;
    localparam int START_BLOCK_HI = 11;
    localparam int START_BLOCK_LO = 8;

    // Register offsets, byte addresses.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CONST = 8'h08;
    localparam logic [7:0] REG_TBL_BASE = 8'h40;
    localparam logic [7:0] REG_TBL_END = 8'h7C;
    localparam int CTRL_EXT_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
endpackage

// file: hdl/dpm_tbl_if.sv
// Purpose: Carries write and read traffic to the trap vector table.
// Assumes: All signals belong to the single block clock.
// Notes: The table owner answers reads one cycle later.
`timescale 1ns/1ns
interface dpm_tbl_if;
    import dpm_pkg::*;
    logic wr_en;
    logic [TBL_AW-1:0] wr_addr;
    logic [VEC_W-1:0] wr_data;
    logic [TBL_AW-1:0] rd_addr;
    logic [VEC_W-1:0] rd_data;
    modport owner (
        input wr_en, wr_addr, wr_data, rd_addr,
        output rd_data
    );
    modport user (
        output wr_en, wr_addr, wr_data, rd_addr,
        input rd_data
    );
endinterface

// file: hdl/dpm_trap_table.sv
// Purpose: Holds the even trap vector for each internal trap condition.
// Assumes: Written by software, read every cycle by the vector logic.
// Notes: Read data is registered; entries clear to zero on reset.
`timescale 1ns/1ns
module dpm_trap_table
    import dpm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    dpm_tbl_if.owner tbl
);
    logic [VEC_W-1:0] mem_reg [TBL_DEPTH];

    // Bit 0 is dropped so every stored vector stays even.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < TBL_DEPTH; i++) begin
                mem_reg[i] <= TBL_RESET;
            end
        end else if (tbl.wr_en) begin
            mem_reg[tbl.wr_addr] <= {tbl.wr_data[VEC_W-1:1], 1'b0};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tbl.rd_data <= TBL_RESET;
        end else begin
            tbl.rd_data <= mem_reg[tbl.rd_addr];
        end
    end
endmodule

// file: test/dpm_top_asserts.sv
// Purpose: Port-level checks for the data-path multiplexer block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every dpm_top instance.
`timescale 1ns/1ns
module dpm_top_asserts
    import dpm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] bus_latch_input_mux_i,
    input wire logic latch_load_enable_i,
    input wire logic phase_one_pulse_i,
    input wire logic long_pause_load_strobe_i,
    input wire logic [15:0] source_operand_reg_i,
    input wire logic [15:0] pcb_i,
    input wire logic [15:0] shifter_i,
    input wire logic [1:0] a_sel_i,
    input wire logic [1:0] b_sel_i,
    input wire logic [1:0] addr_sel_i,
    input wire logic [1:0] small_sel_i,
    input wire logic [1:0] const_select_bits_i,
    input wire logic byte_move_sign_extend_i,
    input wire logic float_bus_op_i,
    input wire logic float_address_step_i,
    input wire logic trap_active_i,
    input wire logic mmu_enable_i,
    input wire logic [15:0] bus_latch_o,
    input wire logic bus_latch_b14_n_o,
    input wire logic [3:0] bus_latch_cc_o,
    input wire logic [15:0] a_operand_mux_o,
    input wire logic [15:0] b_operand_mux_o,
    input wire logic [15:0] address_out_mux_o,
    input wire logic [1:0] phys_addr_top_bits_o,
    input wire logic [3:0] small_const_mux_o,
    input wire logic [15:0] vector_offset_mux_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    latch_inv_a: assert property (
        bus_latch_b14_n_o == !bus_latch_o[14])
        else $error("Inverted bit 14 wrong.");
    latch_cc_a: assert property (
        bus_latch_cc_o == bus_latch_o[3:0]) else $error("Low bits wrong.");
    latch_load_a: assert property (
        latch_load_enable_i && (phase_one_pulse_i || long_pause_load_strobe_i)
        |-> ##2 bus_latch_o == $past(bus_latch_input_mux_i, 2))
        else $error("Latch load wrong.");
    vec_even_a: assert property (
        vector_offset_mux_o[0] == 1'h0) else $error("Vector bit 0 set.");
    small_two_a: assert property (
        small_sel_i == K0_TWO |=> small_const_mux_o ==
        ($past(float_bus_op_i && !float_address_step_i) ? 4'h0 : K0_VAL_TWO))
        else $error("Constant two wrong.");
    mmu_off_a: assert property (
        mmu_enable_i [*2] |=> phys_addr_top_bits_o == 2'h0)
        else $error("Physical bits set with mmu on.");
    amux_pcb_a: assert property (
        a_sel_i == ASEL_PCB |=> a_operand_mux_o == $past(pcb_i))
        else $error("A mux wrong.");
    addr_shift_a: assert property (
        addr_sel_i == ADSEL_SHIFT |=> address_out_mux_o == $past(shifter_i))
        else $error("Address mux wrong.");
    sign_ext_a: assert property (
        byte_move_sign_extend_i && b_sel_i == BSEL_SRC |=>
        b_operand_mux_o == {{8{$past(source_operand_reg_i[7])}},
        $past(source_operand_reg_i[7:0])}) else $error("Byte extend wrong.");
    trap_dflt_a: assert property (
        (const_select_bits_i == K1_TRAP && !trap_active_i) [*3] |=>
        vector_offset_mux_o == 16'h0004) else $error("Default trap wrong.");
endmodule
bind dpm_top dpm_top_asserts u_dpm_top_asserts (.*);

// file: test/dpm_seq_model.sv
// Purpose: Sequencer stand-in that issues latch clock pulses.
// Assumes: fire_i is a one-cycle request from the bench.
// Notes: kind_i picks the long-pause strobe over the phase pulse.
`timescale 1ns/1ns
module dpm_seq_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic kind_i,
    output logic phase_o,
    output logic strobe_o
);
    // Each request becomes exactly one single-cycle pulse.
    always_ff @(posedge clk_i) begin
        phase_o <= fire_i && !kind_i && !rst_i;
        strobe_o <= fire_i && kind_i && !rst_i;
    end
endmodule

// file: test/tb_dpm_top.sv
// Purpose: Self-checking bench for the data-path multiplexer block.
// Assumes: Outputs settle within four cycles of a stable input.
// Notes: Registers are reached over classic Wishbone cycles.
`timescale 1ns/1ns
module tb_dpm_top;
    import dpm_pkg::*;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = 4'hF, src_const_i = 4'h7, dst_const_i = 4'hA;
    logic [3:0] trap_cond_i = '0, bus_latch_cc_o, small_const_mux_o;
    logic [15:0] bus_latch_input_mux_i = '0, source_operand_reg_i = 16'h1111;
    logic [15:0] dest_operand_reg_i = 16'h2222, pcb_i = 16'h3333;
    logic [15:0] shifter_i = 16'h4444, bus_latch_o, a_operand_mux_o;
    logic [15:0] b_operand_mux_o, address_out_mux_o, vector_offset_mux_o;
    logic [1:0] a_sel_i = '0, b_sel_i = '0, addr_sel_i = '0, small_sel_i = '0;
    logic [1:0] const_select_bits_i = '0, phys_addr_top_bits_o;
    logic [5:0] start_vector_i = 6'h20;
    logic wb_we_i = '0, wb_cyc_i = '0, wb_stb_i = '0, wb_ack_o, fire = '0;
    logic kind = '0, latch_load_enable_i = '0, vec_enable_i = '0;
    logic byte_move_sign_extend_i = '0, float_bus_op_i = '0;
    logic float_address_step_i = '0, trap_active_i = '0, mmu_enable_i = '0;
    logic phase_one_pulse_i, long_pause_load_strobe_i, bus_latch_b14_n_o;
    logic [15:0] av[4], bv[4], mv[4];
    logic [3:0] kv[4];
    int failures = 0, samples_checked = 0;
    dpm_top u_dpm_top (.*);
    dpm_seq_model u_dpm_seq_model (.clk_i(clk_i), .rst_i(rst_i),
        .fire_i(fire), .kind_i(kind), .phase_o(phase_one_pulse_i),
        .strobe_o(long_pause_load_strobe_i));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task st;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_adr_i <= {24'h000000, a};
        wb_dat_i <= d;
        wb_we_i <= w;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        do @(posedge clk_i); while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask
    task load(input logic en, input logic k, input logic [15:0] d);
        @(posedge clk_i);
        latch_load_enable_i <= en;
        bus_latch_input_mux_i <= d;
        fire <= 1'h1;
        kind <= k;
        @(posedge clk_i);
        fire <= 1'h0;
        st;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_i);
        failures++;
        tally_and_finish();
    end
    initial begin
        av = '{16'h1111, 16'h2222, 16'h3333, 16'h4085};
        bv = '{16'h0007, 16'h4085, 16'h1111, 16'h2222};
        mv = '{16'h3333, 16'h1111, 16'h2222, 16'h4444};
        kv = '{4'h7, 4'hA, 4'h1, 4'h2};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        #1;
        chk("b14n", bus_latch_b14_n_o, 32'h1);
        wbx(1'h0, REG_CTRL, 32'h0);
        chk("ctrl", rd, CTRL_RESET);
        load(1'h1, 1'h1, 16'h4085);
        chk("latch", bus_latch_o, 32'h4085);
        chk("b14n", bus_latch_b14_n_o, 32'h0);
        chk("cc", bus_latch_cc_o, 32'h5);
        load(1'h0, 1'h0, 16'h1234);
        chk("latch", bus_latch_o, 32'h4085);
        load(1'h1, 1'h0, 16'h1234);
        chk("latch", bus_latch_o, 32'h1234);
        chk("cc", bus_latch_cc_o, 32'h4);
        load(1'h1, 1'h0, 16'h4085);
        wbx(1'h0, REG_STATUS, 32'h0);
        chk("status", rd, 32'h0000_4085);
        wbx(1'h0, 8'h20, 32'h0);
        chk("unmapped", rd, 32'h0);
        $display("latch test done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            a_sel_i <= 2'(i);
            b_sel_i <= 2'(i);
            addr_sel_i <= 2'(i);
            small_sel_i <= 2'(i);
            st;
            chk("a", a_operand_mux_o, av[i]);
            chk("b", b_operand_mux_o, (i == 0) ? bv[0] : bv[i]);
            chk("addr", address_out_mux_o, mv[i]);
            chk("small", small_const_mux_o, kv[i]);
        end
        @(posedge clk_i);
        b_sel_i <= BSEL_CONST;
        float_bus_op_i <= 1'h1;
        st;
        chk("small", small_const_mux_o, 32'h0);
        @(posedge clk_i);
        float_address_step_i <= 1'h1;
        st;
        chk("b", b_operand_mux_o, 32'h0002);
        $display("mux test done");
        @(posedge clk_i);
        vec_enable_i <= 1'h1;
        const_select_bits_i <= K1_START;
        st;
        chk("vec", vector_offset_mux_o, 32'hF680);
        chk("b", b_operand_mux_o, 32'hF680);
        @(posedge clk_i);
        start_vector_i <= 6'h1F;
        st;
        chk("vec", vector_offset_mux_o, 32'h007C);
        @(posedge clk_i);
        const_select_bits_i <= K1_LOOP;
        st;
        chk("vec", vector_offset_mux_o, 32'h000A);
        @(posedge clk_i);
        const_select_bits_i <= K1_BRANCH;
        st;
        chk("vec", vector_offset_mux_o, 32'hFF0A);
        wbx(1'h1, 8'h4C, 32'h1B);
        @(posedge clk_i);
        const_select_bits_i <= K1_TRAP;
        trap_cond_i <= 4'h3;
        st;
        chk("vec", vector_offset_mux_o, 32'h0004);
        @(posedge clk_i);
        trap_active_i <= 1'h1;
        st;
        chk("vec", vector_offset_mux_o, 32'h0018);
        @(posedge clk_i);
        trap_cond_i <= 4'h0;
        st;
        chk("vec", vector_offset_mux_o, 32'h0004);
        @(posedge clk_i);
        vec_enable_i <= 1'h0;
        b_sel_i <= BSEL_SRC;
        source_operand_reg_i <= 16'h1280;
        byte_move_sign_extend_i <= 1'h1;
        st;
        chk("b", b_operand_mux_o, 32'hFF80);
        @(posedge clk_i);
        b_sel_i <= BSEL_LATCH;
        st;
        chk("b", b_operand_mux_o, 32'hFF85);
        $display("vector test done");
        @(posedge clk_i);
        addr_sel_i <= ADSEL_PCB;
        pcb_i <= 16'hE000;
        st;
        chk("phys", phys_addr_top_bits_o, 32'h3);
        @(posedge clk_i);
        pcb_i <= 16'hC000;
        st;
        chk("phys", phys_addr_top_bits_o, 32'h0);
        @(posedge clk_i);
        pcb_i <= 16'hE000;
        mmu_enable_i <= 1'h1;
        st;
        chk("phys", phys_addr_top_bits_o, 32'h0);
        @(posedge clk_i);
        mmu_enable_i <= 1'h0;
        wbx(1'h1, REG_CTRL, 32'h0);
        st;
        chk("phys", phys_addr_top_bits_o, 32'h0);
        wbx(1'h0, REG_CTRL, 32'h0);
        chk("ctrl", rd, 32'h0);
        $display("address test done");
        tally_and_finish();
    end
endmodule
